// ---- qdi_pkg.sv ----
// Shared constants and types for the quad DAC two-wire write receiver.
// Assumes a single system clock domain; bus pins are resynchronised inside.
package qdi_pkg;

  // Byte framing
  localparam int          BYTE_BITS      = 8;
  localparam logic [3:0]  BIT_CNT_FULL   = 4'h8;
  localparam logic [3:0]  BIT_CNT_ZERO   = 4'h0;
  localparam logic [3:0]  BIT_CNT_ONE    = 4'h1;

  // Address byte layout
  localparam logic [4:0]  ADDR_PREFIX    = 5'h13;
  localparam int          ADDR_PFX_MSB   = 7;
  localparam int          ADDR_PFX_LSB   = 3;
  localparam int          ADDR_BIT1_POS  = 2;
  localparam int          ADDR_BIT0_POS  = 1;
  localparam int          ADDR_RW_POS    = 0;

  // High-speed master code, upper five bits
  localparam logic [4:0]  MCODE_PREFIX   = 5'h01;

  // Control byte layout
  localparam int          CTRL_PKG_UPPER = 7;
  localparam int          CTRL_PKG_LOWER = 6;
  localparam int          CTRL_LOAD_MSB  = 5;
  localparam int          CTRL_LOAD_LSB  = 4;
  localparam int          CTRL_CHAN_MSB  = 2;
  localparam int          CTRL_CHAN_LSB  = 1;
  localparam int          CTRL_PD_POS    = 0;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;

  // Load modes
  localparam logic [1:0]  LOAD_TEMP      = 2'h0;
  localparam logic [1:0]  LOAD_SINGLE    = 2'h1;
  localparam logic [1:0]  LOAD_ALL       = 2'h2;
  localparam logic [1:0]  LOAD_BCAST     = 2'h3;

  // Power-down code bits inside the high byte
  localparam int          PD_CODE_HI_POS = 7;
  localparam int          PD_CODE_LO_POS = 6;

  // Which byte of the write sequence is expected next
  typedef enum logic [1:0] {
    STG_ADDR,
    STG_CTRL,
    STG_HIGH,
    STG_LOW
  } qdi_stage_t;

  // One channel update, handed out at the low-byte acknowledge
  typedef struct packed {
    logic [1:0] channel;
    logic [1:0] loadMode;
    logic       powerdownSelectBit;
    logic       broadcast;
    logic [7:0] highByte;
  } qdi_update_t;

  localparam qdi_update_t UPDATE_RESET = '0;

endpackage

// ---- qdi_write_receiver.sv ----
// Write-side slave receiver of a quad 8-bit DAC on a two-wire bus.
// Assumes clock far faster than the bus clock; SCL and SDA are oversampled.
`timescale 1ns/10ps
`default_nettype none

module qdi_write_receiver
  import qdi_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic        clock,              // System clock, 125 MHz
  input  wire logic        reset_n,            // Asynchronous reset
  input  wire logic        clkEn,              // Freezes all state when low
  input  wire logic        sclPin,             // Bus clock pin
  input  wire logic        sdaIn,              // Bus data pin level
  output var  logic        sdaOut,             // Data drive level, always 0
  output var  logic        sdaOe,              // High while pulling SDA low
  input  wire logic        pkgAddrUpper,       // Package address strap, upper
  input  wire logic        pkgAddrLower,       // Package address strap, lower
  input  wire logic        slaveAddrBitOne,    // Slave address strap, bit 1
  input  wire logic        slaveAddrBitZero,   // Slave address strap, bit 0
  output var  logic        updValid,           // Update word waiting
  output var  qdi_update_t updWord,            // Update word
  input  wire logic        updReady,           // Consumer takes the word
  output var  logic [7:0]  ctrlReg,            // Last accepted control byte
  output var  logic        hsMode,             // High-speed entry seen
  output var  logic        busBusy             // Between START and STOP
);

  localparam int NUM_PINS = 6;

  typedef enum logic [1:0] {ST_IDLE, ST_BITS, ST_ACK, ST_SKIP} qdi_state_t;

  // Address decode is needed for both ack and skip decisions
  function automatic logic addrMatch(input logic [7:0] b,
                                     input logic a1, input logic a0);
    addrMatch = (b[ADDR_PFX_MSB:ADDR_PFX_LSB] == ADDR_PREFIX) &&
                (b[ADDR_BIT1_POS] == a1) &&
                (b[ADDR_BIT0_POS] == a0) &&
                !b[ADDR_RW_POS];
  endfunction

  function automatic logic isMasterCode(input logic [7:0] b);
    isMasterCode = (b[ADDR_PFX_MSB:ADDR_PFX_LSB] == MCODE_PREFIX);
  endfunction

  // Pin synchronisers
  logic [NUM_PINS-1:0] pinRaw, syncStage1_ff, syncStage2_ff;

  assign pinRaw = {sclPin, sdaIn, pkgAddrUpper, pkgAddrLower,
                   slaveAddrBitOne, slaveAddrBitZero};

  for (genvar gi = 0; gi < NUM_PINS; gi++) begin : g_sync
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        syncStage1_ff[gi] <= 1'b1;
        syncStage2_ff[gi] <= 1'b1;
      end else if (clkEn) begin
        syncStage1_ff[gi] <= pinRaw[gi];
        syncStage2_ff[gi] <= syncStage1_ff[gi];
      end
    end
  end

  logic sclS, sdaS, a3S, a2S, a1S, a0S;
  assign {sclS, sdaS, a3S, a2S, a1S, a0S} = syncStage2_ff;

  // Edge and condition detection
  logic sclPrev_ff, sdaPrev_ff;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end else if (clkEn) begin
      sclPrev_ff <= sclS;
      sdaPrev_ff <= sdaS;
    end
  end

  logic sclRise, sclFall, startCond, stopCond;
  assign sclRise   = sclS && !sclPrev_ff;
  assign sclFall   = !sclS && sclPrev_ff;
  assign startCond = sclS && sclPrev_ff && sdaPrev_ff && !sdaS;
  assign stopCond  = sclS && sclPrev_ff && !sdaPrev_ff && sdaS;

  // Byte machine state
  qdi_state_t  state_ff;
  qdi_state_t  nxt_state;
  qdi_stage_t  stage_ff;
  qdi_stage_t  nxt_stage;
  logic [3:0]  bitCnt_ff;
  logic [7:0]  shift_ff;
  logic [7:0]  ctrl_ff;
  logic [7:0]  high_ff;
  logic        acking_ff, lastByte_ff;
  logic        bufRoom, ackNow, mcodeNow;
  logic        byteEnd, ackEnd, pushUpd;
  logic [1:0]  rxLoad;

  assign byteEnd = (state_ff == ST_BITS) && sclFall &&
                   (bitCnt_ff == BIT_CNT_FULL);
  assign ackEnd  = (state_ff == ST_ACK) && sclFall;
  assign rxLoad  = shift_ff[CTRL_LOAD_MSB:CTRL_LOAD_LSB];

  // Acknowledge decision for the byte just shifted in
  always_comb begin
    ackNow    = 1'b0;
    mcodeNow  = 1'b0;
    nxt_stage = stage_ff;
    case (stage_ff)
      STG_ADDR: begin
        mcodeNow = isMasterCode(shift_ff);
        ackNow   = addrMatch(shift_ff, a1S, a0S);
        nxt_stage = STG_CTRL;
      end
      STG_CTRL: begin
        ackNow = (rxLoad == LOAD_BCAST) ||
                 ((shift_ff[CTRL_PKG_UPPER] == a3S) &&
                  (shift_ff[CTRL_PKG_LOWER] == a2S));
        nxt_stage = STG_HIGH;
      end
      STG_HIGH: begin
        ackNow    = 1'b1;
        nxt_stage = STG_LOW;
      end
      STG_LOW: begin
        // No room means no ack, so the master sees the stall
        ackNow    = bufRoom;
        nxt_stage = STG_HIGH;
      end
      default: nxt_stage = STG_ADDR;
    endcase
  end

  // Next state of the byte machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = ST_IDLE;
      ST_BITS: nxt_state = byteEnd ? ST_ACK : ST_BITS;
      ST_ACK: begin
        if (ackEnd) begin
          nxt_state = (acking_ff && !lastByte_ff) ? ST_BITS : ST_SKIP;
        end
      end
      ST_SKIP: nxt_state = ST_SKIP;
      default: nxt_state = ST_IDLE;
    endcase
    // START and repeated START always restart at the address byte
    if (startCond) begin
      nxt_state = ST_BITS;
    end else if (stopCond) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
    end else if (clkEn) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage_ff <= STG_ADDR;
    end else if (clkEn) begin
      if (startCond) begin
        stage_ff <= STG_ADDR;
      end else if (ackEnd && acking_ff) begin
        stage_ff <= nxt_stage;
      end
    end
  end

  // Bit counter and shift register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt_ff <= BIT_CNT_ZERO;
      shift_ff  <= BYTE_RESET;
    end else if (clkEn) begin
      if (startCond || ackEnd) begin
        bitCnt_ff <= BIT_CNT_ZERO;
      end else if ((state_ff == ST_BITS) && sclRise &&
                   (bitCnt_ff != BIT_CNT_FULL)) begin
        bitCnt_ff <= bitCnt_ff + BIT_CNT_ONE;
        shift_ff  <= {shift_ff[BYTE_BITS-2:0], sdaS};
      end
    end
  end

  // Acknowledge drive; released at the fall ending the ninth clock
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acking_ff   <= 1'b0;
      lastByte_ff <= 1'b0;
    end else if (clkEn) begin
      if (startCond || stopCond || ackEnd) begin
        acking_ff   <= 1'b0;
        lastByte_ff <= 1'b0;
      end else if (byteEnd) begin
        acking_ff   <= ackNow;
        // Power-down takes one pair, later bytes go unanswered
        lastByte_ff <= (stage_ff == STG_LOW) &&
                       ctrl_ff[CTRL_PD_POS];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sdaOe  <= 1'b0;
      sdaOut <= 1'b0;
    end else if (clkEn) begin
      sdaOut <= 1'b0;
      if (startCond || stopCond || ackEnd) begin
        sdaOe <= 1'b0;
      end else if (byteEnd) begin
        sdaOe <= ackNow;
      end
    end
  end

  // Control and high-byte capture
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RESET;
      high_ff <= BYTE_RESET;
    end else if (clkEn) begin
      if (byteEnd && ackNow && (stage_ff == STG_CTRL))
        ctrl_ff <= shift_ff;
      if (byteEnd && (stage_ff == STG_HIGH))
        high_ff <= shift_ff;
    end
  end

  assign ctrlReg = ctrl_ff;

  // Speed mode and bus activity flags
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hsMode  <= 1'b0;
      busBusy <= 1'b0;
    end else if (clkEn) begin
      if (stopCond) begin
        hsMode  <= 1'b0;
        busBusy <= 1'b0;
      end else begin
        if (startCond) busBusy <= 1'b1;
        if (byteEnd && (stage_ff == STG_ADDR) && mcodeNow) begin
          hsMode <= 1'b1;
        end
      end
    end
  end

  // Two-entry buffer; the output slot is a flop so a stall loses nothing
  qdi_update_t slot0_ff, slot1_ff, pushWord;
  logic        slot1Valid_ff, popUpd;

  assign pushUpd = ackEnd && acking_ff && (stage_ff == STG_LOW);
  assign popUpd  = updValid && updReady;
  assign bufRoom = !slot1Valid_ff;

  always_comb begin
    pushWord                    = UPDATE_RESET;
    pushWord.channel            = ctrl_ff[CTRL_CHAN_MSB:CTRL_CHAN_LSB];
    pushWord.loadMode           = ctrl_ff[CTRL_LOAD_MSB:CTRL_LOAD_LSB];
    pushWord.powerdownSelectBit = ctrl_ff[CTRL_PD_POS];
    pushWord.broadcast          = (pushWord.loadMode == LOAD_BCAST);
    pushWord.highByte           = high_ff;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      updValid      <= 1'b0;
      slot1Valid_ff <= 1'b0;
      slot0_ff      <= UPDATE_RESET;
      slot1_ff      <= UPDATE_RESET;
    end else if (clkEn) begin
      case ({pushUpd, popUpd})
        2'h2: begin
          if (!updValid) begin
            slot0_ff <= pushWord;
            updValid <= 1'b1;
          end else begin
            slot1_ff      <= pushWord;
            slot1Valid_ff <= 1'b1;
          end
        end
        2'h1: begin
          slot0_ff      <= slot1_ff;
          updValid      <= slot1Valid_ff;
          slot1Valid_ff <= 1'b0;
        end
        2'h3: begin
          if (slot1Valid_ff) begin
            slot0_ff <= slot1_ff;
            slot1_ff <= pushWord;
          end else begin
            slot0_ff <= pushWord;
          end
        end
        default: slot0_ff <= slot0_ff;
      endcase
    end
  end

  assign updWord = slot0_ff;

endmodule // qdi_write_receiver

`default_nettype wire

// ---- qdi_write_receiver_props.sv ----
// Port checker for the two-wire write receiver.
// Bound to the receiver; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module qdi_write_receiver_props
  import qdi_pkg::*;
(
  input wire logic        clock,    // Clock
  input wire logic        reset_n,  // Reset
  input wire logic        sclPin,   // Bus clock
  input wire logic        sdaIn,    // Bus data
  input wire logic        sdaOut,   // Drive level
  input wire logic        sdaOe,    // Drive enable
  input wire logic        updValid, // Word waiting
  input wire qdi_update_t updWord,  // Word
  input wire logic        updReady, // Consumer ready
  input wire logic        hsMode,   // High speed seen
  input wire logic        busBusy   // Bus busy
);
  logic       sclQ_ff;
  logic [2:0] sinceFall_ff;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Clocks since the last pin-level SCL fall, saturating
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclQ_ff <= 1'b1;
      sinceFall_ff <= 3'h7;
    end else begin
      sclQ_ff <= sclPin;
      if (sclQ_ff && !sclPin)
        sinceFall_ff <= 3'h0;
      else if (sinceFall_ff != 3'h7)
        sinceFall_ff <= sinceFall_ff + 3'h1;
    end
  end
  sequence startSeq;
    sclPin && $past(sclPin) && $fell(sdaIn);
  endsequence
  sequence stopSeq;
    sclPin && $past(sclPin) && $rose(sdaIn);
  endsequence
  a_drive_zero: assert property (sdaOut == 1'b0)
    else $error("data drive level not low");
  a_ack_timing: assert property ($rose(sdaOe) |-> sinceFall_ff inside {[3'h1:3'h6]})
    else $error("acknowledge not tied to clock fall");
  a_ack_holds: assert property (sdaOe && $rose(sclPin) |-> sdaOe [*3])
    else $error("acknowledge dropped while clock high");
  a_upd_timing: assert property ($rose(updValid) |-> sinceFall_ff inside {[3'h1:3'h6]})
    else $error("update not at acknowledge fall");
  a_word_holds: assert property (updValid && !updReady |=> updValid && $stable(updWord))
    else $error("update word lost under stall");
  a_bcast_flag: assert property (updValid |-> updWord.broadcast == (updWord.loadMode == LOAD_BCAST))
    else $error("broadcast flag wrong");
  a_start_busy: assert property (startSeq |-> ##[1:6] busBusy)
    else $error("start not seen");
  a_stop_idle: assert property (stopSeq |-> ##[1:6] !busBusy)
    else $error("stop not seen");
  a_stop_hs: assert property (stopSeq |-> ##[1:6] !hsMode)
    else $error("high speed flag kept after stop");
endmodule // qdi_write_receiver_props

bind qdi_write_receiver qdi_write_receiver_props u_props (.clock(clock),
  .reset_n(reset_n), .sclPin(sclPin), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .updValid(updValid), .updWord(updWord),
  .updReady(updReady), .hsMode(hsMode), .busBusy(busBusy));
`default_nettype wire

// ---- qdi_bus_master.sv ----
// Two-wire bus master model for the receiver's bus pins.
// Data wire is pulled up; low while either side pulls it.
`timescale 1ns/10ps
`default_nettype none
module qdi_bus_master (
  input  wire logic clock,  // System clock
  input  wire logic slow,   // Stretch the low phase
  input  wire logic sdaOe,  // Receiver pulls data low
  output var  logic sclPin, // Bus clock
  output wire logic sdaIn   // Data wire level
);
  logic pullLow;
  assign sdaIn = !(pullLow || sdaOe);
  initial begin
    sclPin = 1'b1;
    pullLow = 1'b0;
  end
  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // 80 ns bit, 112 ns with slow: data moves only while the clock is low
  task automatic bitOut(input logic b, output logic seen);
    waitc(slow ? 6 : 2);
    pullLow <= !b;
    waitc(3);
    sclPin <= 1'b1;
    waitc(3);
    seen = sdaIn;
    waitc(2);
    sclPin <= 1'b0;
  endtask
  // Also a repeated start; waits out the receiver's ack release
  task automatic startCond();
    waitc(4);
    pullLow <= 1'b0;
    waitc(3);
    sclPin <= 1'b1;
    waitc(4);
    pullLow <= 1'b1;
    waitc(4);
    sclPin <= 1'b0;
  endtask
  task automatic stopCond();
    waitc(4);
    pullLow <= 1'b1;
    waitc(3);
    sclPin <= 1'b1;
    waitc(4);
    pullLow <= 1'b0;
    waitc(4);
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--)
      bitOut(b[i], seen);
    bitOut(1'b1, seen);
    ack = !seen;
  endtask
endmodule // qdi_bus_master
`default_nettype wire

// ---- qdi_write_receiver_tb.sv ----
// Self-checking bench for the two-wire write receiver.
// Master model drives the pins; bench consumes update words.
`timescale 1ns/10ps
`default_nettype none
module qdi_write_receiver_tb
  import qdi_pkg::*;
;
  logic clock, reset_n, slow, updReady, hold, ack;
  logic sclPin, sdaIn, sdaOut, sdaOe, updValid, hsMode, busBusy;
  logic pkgUp, pkgLo, bitOne, bitZero;
  logic [1:0] ch;
  logic [7:0] ctrlReg, curCtrl;
  qdi_update_t updWord;
  qdi_update_t expQ[$];
  int num_errors, n_checks;
  qdi_bus_master u_qdi_bus_master (.clock(clock), .slow(slow),
    .sdaOe(sdaOe), .sclPin(sclPin), .sdaIn(sdaIn));
  qdi_write_receiver u_qdi_write_receiver (.clock(clock),
    .reset_n(reset_n), .clkEn(1'b1), .sclPin(sclPin), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .pkgAddrUpper(pkgUp),
    .pkgAddrLower(pkgLo), .slaveAddrBitOne(bitOne),
    .slaveAddrBitZero(bitZero), .updValid(updValid), .updWord(updWord),
    .updReady(updReady), .ctrlReg(ctrlReg), .hsMode(hsMode),
    .busBusy(busBusy));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Consumer pops at random; an unexpected word is a mismatch
  always @(posedge clock) begin
    if (updValid && updReady) begin
      if (expQ.size() == 0)
        chk(16'(updWord), 16'hffff);
      else
        chk(16'(updWord), 16'(expQ.pop_front()));
    end
    updReady <= !hold && ($urandom % 2 == 1);
  end
  task automatic xfer(input logic [7:0] b, input logic expAck);
    u_qdi_bus_master.sendByte(b, ack);
    chk(16'(ack), 16'(expAck));
  endtask
  task automatic beginWrite(input logic [7:0] ctrl, input logic ctrlAck);
    u_qdi_bus_master.startCond();
    xfer({ADDR_PREFIX, bitOne, bitZero, 1'b0}, 1'b1);
    curCtrl = ctrl;
    xfer(ctrl, ctrlAck);
  endtask
  task automatic pair(input logic [7:0] hi, input logic lowAck);
    xfer(hi, 1'b1);
    if (lowAck)
      expQ.push_back({curCtrl[2:1], curCtrl[5:4], curCtrl[0],
        curCtrl[5:4] == LOAD_BCAST, hi});
    xfer(8'($urandom), lowAck);
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    reset_n = 1'b0;
    slow = 1'b0;
    hold = 1'b0;
    void'($urandom(32'h0000_cbf8));
    {pkgUp, pkgLo, bitOne, bitZero} = 4'($urandom);
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    // Every load mode, chained by repeated start
    for (int m = 0; m < 4; m++) begin
      ch = 2'($urandom);
      slow <= m[0];
      beginWrite({pkgUp, pkgLo, 2'(m), 1'b0, ch, 1'b0}, 1'b1);
      repeat (2) pair(8'($urandom), 1'b1);
      chk(16'(ctrlReg), 16'(curCtrl));
    end
    $display("test load modes done");
    beginWrite({pkgUp, pkgLo, LOAD_SINGLE, 1'b0, ch, 1'b1}, 1'b1);
    pair({2'($urandom), 6'h00}, 1'b1);
    xfer(8'h00, 1'b0);
    u_qdi_bus_master.stopCond();
    $display("test power-down done");
    beginWrite({~pkgUp, pkgLo, LOAD_TEMP, 1'b0, ch, 1'b0}, 1'b0);
    beginWrite({~pkgUp, ~pkgLo, LOAD_BCAST, 1'b0, ch, 1'b0}, 1'b1);
    pair(8'($urandom), 1'b1);
    u_qdi_bus_master.startCond();
    xfer({ADDR_PREFIX, ~bitOne, bitZero, 1'b0}, 1'b0);
    chk(16'(busBusy), 16'h1);
    xfer(8'h98, 1'b0);
    u_qdi_bus_master.startCond();
    xfer({ADDR_PREFIX ^ 5'h01, bitOne, bitZero, 1'b0}, 1'b0);
    u_qdi_bus_master.startCond();
    xfer({ADDR_PREFIX, bitOne, bitZero, 1'b1}, 1'b0);
    u_qdi_bus_master.stopCond();
    $display("test refusals done");
    u_qdi_bus_master.startCond();
    xfer({MCODE_PREFIX, 3'($urandom)}, 1'b0);
    repeat (6) @(posedge clock);
    chk(16'(hsMode), 16'h1);
    slow <= 1'b0;
    beginWrite({pkgUp, pkgLo, LOAD_ALL, 1'b0, ch, 1'b0}, 1'b1);
    pair(8'($urandom), 1'b1);
    u_qdi_bus_master.stopCond();
    chk(16'(hsMode), 16'h0);
    $display("test high speed done");
    // Stalled consumer: two words fit, third low byte refused
    while (expQ.size() != 0) @(posedge clock);
    hold <= 1'b1;
    beginWrite({pkgUp, pkgLo, LOAD_TEMP, 1'b0, ch, 1'b0}, 1'b1);
    repeat (2) pair(8'($urandom), 1'b1);
    pair(8'($urandom), 1'b0);
    xfer(8'($urandom), 1'b0);
    u_qdi_bus_master.stopCond();
    hold <= 1'b0;
    for (int i = 0; i < 200 && expQ.size() != 0; i++)
      @(posedge clock);
    chk(16'(expQ.size()), 16'h0000);
    $display("test full buffer done");
    tally_and_finish();
  end
endmodule // qdi_write_receiver_tb
`default_nettype wire
